/* File: shared/sbc_cfg.svh */
// Purpose: Shared constants of the SMBus block-configuration link and its two ends.
// Assumes: 50 MHz ref_clk_i; open-drain link wires resolved in the interface.
// Notes: Function list follows.
//
// Function
// - Respond only to address bytes D2h (write) and D3h (read).
// - All registers load defaults at power-up.
// - Bytes go ascending, most significant bit first.
// - Stop after any byte keeps finished bytes.
// - Host sends start, address, write; device acks.
// - Command zero selects block; device acks it.
// - Block write: count, then data; ack each.
// - Block write ends with stop after ack.
// - Block read: repeated start, read, count, data.
// - Host acks count and data except last.
// - Final byte nacked, stop; device releases line.
// - Select bit low: power-down clears registers.
// - Power-down with select bit low enters latches-open, resets everything.
// - Command msb set selects single byte offset.
// - Power-down select bit resets to one.
`ifndef SBC_CFG_SVH
`define SBC_CFG_SVH

`define SBC_ADDR7 7'h69
`define SBC_DIR_WRITE 1'b0
`define SBC_DIR_READ 1'b1
`define SBC_CMD_BLOCK 8'h00
`define SBC_CMD_SINGLE_BIT 7
`define SBC_PD_SEL_BIT 0
`define SBC_LAST_BIT 4'h7
`define SBC_ACK_SLOT 4'h8
`define SBC_FIRST_BIT 4'h0
`define SBC_IDX_NONE 8'hff
`define SBC_NUM_BYTES 8
// Byte 7 in the top lane, byte 0 in the bottom lane.
`define SBC_REG_DEFAULTS 64'h000000ffffff0301
`define SBC_WR_MASK 64'hfffeffffffffff1f
`define SBC_STICKY_MASK 64'h0000000000000010
`define SBC_CLK_PERIOD_NS 20
`define SBC_SCL_PERIOD_NS 320
`define SBC_QUARTER_CYCLES (`SBC_SCL_PERIOD_NS / (4 * `SBC_CLK_PERIOD_NS))
`define SBC_LAST_QUARTER 2'h3

`endif

/* File: shared/sbc_pkg.sv */
// Purpose: Types shared by the two ends of the configuration link.
// Assumes: Nothing beyond the constants header.
// Notes: Gray codes follow the usual path of a transfer.
package sbc_pkg;

   typedef enum logic [2:0] {
      DEV_IDLE  = 3'h0,
      DEV_ADDR  = 3'h1,
      DEV_CMD   = 3'h3,
      DEV_COUNT = 3'h2,
      DEV_WDATA = 3'h6,
      DEV_TX    = 3'h7,
      DEV_IGN   = 3'h5
   } sbc_dev_state_type;

   typedef enum logic [3:0] {
      HST_IDLE   = 4'h0,
      HST_START  = 4'h1,
      HST_ADDR   = 4'h3,
      HST_CMD    = 4'h2,
      HST_WCOUNT = 4'h6,
      HST_WDATA  = 4'h7,
      HST_RSTART = 4'h5,
      HST_RADDR  = 4'h4,
      HST_RCOUNT = 4'hc,
      HST_RDATA  = 4'hd,
      HST_STOP   = 4'hf
   } sbc_host_state_type;

endpackage

/* File: shared/sbc_if.sv */
// Purpose: Two-wire open-drain link between the host end and the device end.
// Assumes: An external pull-up holds each wire high when nobody drives it.
// Notes: The wire levels are resolved here from the enables.
`timescale 1ns/1ps
interface sbc_if;
   logic host_scl_o;
   logic host_scl_oe;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic scl;
   logic sda;

   assign scl = ~(host_scl_oe & ~host_scl_o);
   assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

   modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
   modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
      output host_sda_o, output host_sda_oe);
endinterface

/* File: hdl/sbc_dev.sv */
// Purpose: Device end: SMBus slave holding the configuration byte registers.
// Assumes: Link wires sampled on ref_clk_i; the host does not need clock stretching.
// Notes: A full power cycle is emulated by the power-down request when selected.
`timescale 1ns/1ps
`include "sbc_cfg.svh"
module sbc_dev #(
   parameter int NB = `SBC_NUM_BYTES,
   parameter logic [8*NB-1:0] DEFAULTS = `SBC_REG_DEFAULTS,
   parameter logic [8*NB-1:0] WR_MASK = `SBC_WR_MASK,
   parameter logic [8*NB-1:0] STICKY = `SBC_STICKY_MASK
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   // Power management
   input wire logic powerdown_request_n_i,
   // Serial link
   sbc_if.dev link,
   // Configuration outputs
   output logic [8*NB-1:0] cfg_o,
   output logic latches_open_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers with agreement filter.

   logic [2:0] scl_s;
   logic [2:0] sda_s;
   logic [2:0] pdn_s;
   logic [2:0] next_scl_s;
   logic [2:0] next_sda_s;
   logic [2:0] next_pdn_s;
   logic scl_f;
   logic sda_f;
   logic pdn_f;
   logic scl_p;
   logic sda_p;
   logic next_scl_f;
   logic next_sda_f;
   logic next_pdn_f;

   always_comb begin
      next_scl_s = {scl_s[1:0], link.scl};
      next_sda_s = {sda_s[1:0], link.sda};
      next_pdn_s = {pdn_s[1:0], powerdown_request_n_i};
      next_scl_f = (scl_s[1] == scl_s[2]) ? scl_s[2] : scl_f;
      next_sda_f = (sda_s[1] == sda_s[2]) ? sda_s[2] : sda_f;
      next_pdn_f = (pdn_s[1] == pdn_s[2]) ? pdn_s[2] : pdn_f;
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         scl_s <= 3'h7;
         sda_s <= 3'h7;
         pdn_s <= 3'h7;
         scl_f <= 1'b1;
         sda_f <= 1'b1;
         pdn_f <= 1'b1;
         scl_p <= 1'b1;
         sda_p <= 1'b1;
      end else begin
         scl_s <= next_scl_s;
         sda_s <= next_sda_s;
         pdn_s <= next_pdn_s;
         scl_f <= next_scl_f;
         sda_f <= next_sda_f;
         pdn_f <= next_pdn_f;
         scl_p <= scl_f;
         sda_p <= sda_f;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transfer engine and register bank.

   sbc_pkg::sbc_dev_state_type state;
   sbc_pkg::sbc_dev_state_type next_state;
   logic [3:0] bit_cnt;
   logic [3:0] next_bit_cnt;
   logic [7:0] shift;
   logic [7:0] next_shift;
   logic [7:0] idx;
   logic [7:0] next_idx;
   logic sda_low;
   logic next_sda_low;
   logic block;
   logic next_block;
   logic tx_first;
   logic next_tx_first;
   logic acked;
   logic next_acked;
   logic latches;
   logic next_latches;
   logic [7:0] regs [NB];
   logic [7:0] next_regs [NB];

   function automatic logic [7:0] rd_byte(input logic [7:0] i);
      logic [7:0] r;
      r = 8'h00;
      for (int k = 0; k < NB; k++) begin
         if (i == 8'(k)) begin
            r = regs[k];
         end
      end
      return r;
   endfunction

   function automatic logic [7:0] inc_idx(input logic [7:0] i);
      return (i == `SBC_IDX_NONE) ? i : i + 8'h01;
   endfunction

   always_comb begin
      logic rise;
      logic fall;
      logic start;
      logic stop;
      logic [7:0] tx_byte;
      rise = scl_f & ~scl_p;
      fall = ~scl_f & scl_p;
      start = scl_f & scl_p & sda_p & ~sda_f;
      stop = scl_f & scl_p & ~sda_p & sda_f;
      tx_byte = 8'h00;
      next_state = state;
      next_bit_cnt = bit_cnt;
      next_shift = shift;
      next_idx = idx;
      next_sda_low = sda_low;
      next_block = block;
      next_tx_first = tx_first;
      next_acked = acked;
      next_regs = regs;
      // The request is held as a level; the bank stays cleared while it lasts.
      next_latches = ~pdn_f & (latches | ~regs[0][`SBC_PD_SEL_BIT]);
      if (next_latches) begin
         next_state = sbc_pkg::DEV_IDLE;
         next_bit_cnt = `SBC_FIRST_BIT;
         next_sda_low = 1'b0;
         next_block = 1'b0;
         next_tx_first = 1'b0;
         next_idx = 8'h00;
         for (int k = 0; k < NB; k++) begin
            next_regs[k] = DEFAULTS[8*k +: 8];
         end
      end else if (start) begin
         next_state = sbc_pkg::DEV_ADDR;
         // The fall that ends a start carries no data bit, so it passes as an ack slot.
         next_bit_cnt = `SBC_ACK_SLOT;
         next_sda_low = 1'b0;
      end else if (stop) begin
         next_state = sbc_pkg::DEV_IDLE;
         next_sda_low = 1'b0;
      end else if (state != sbc_pkg::DEV_IDLE && state != sbc_pkg::DEV_IGN) begin
         if (rise) begin
            if (bit_cnt == `SBC_ACK_SLOT) begin
               next_acked = ~sda_f;
            end else begin
               next_shift = {shift[6:0], sda_f};
            end
         end
         if (fall) begin
            if (bit_cnt == `SBC_LAST_BIT) begin
               next_bit_cnt = `SBC_ACK_SLOT;
               unique case (state)
                  sbc_pkg::DEV_ADDR: begin
                     if (shift[7:1] == `SBC_ADDR7) begin
                        next_sda_low = 1'b1;
                        next_tx_first = shift[0];
                        next_state = shift[0] ? sbc_pkg::DEV_TX : sbc_pkg::DEV_CMD;
                     end else begin
                        next_state = sbc_pkg::DEV_IGN;
                     end
                  end
                  sbc_pkg::DEV_CMD: begin
                     if (shift == `SBC_CMD_BLOCK) begin
                        next_sda_low = 1'b1;
                        next_block = 1'b1;
                        next_idx = 8'h00;
                        next_state = sbc_pkg::DEV_COUNT;
                     end else if (shift[`SBC_CMD_SINGLE_BIT]) begin
                        next_sda_low = 1'b1;
                        next_block = 1'b0;
                        next_idx = {1'b0, shift[6:0]};
                        next_state = sbc_pkg::DEV_WDATA;
                     end else begin
                        next_state = sbc_pkg::DEV_IGN;
                     end
                  end
                  sbc_pkg::DEV_COUNT: begin
                     next_sda_low = 1'b1;
                     next_state = sbc_pkg::DEV_WDATA;
                  end
                  sbc_pkg::DEV_WDATA: begin
                     next_sda_low = 1'b1;
                     for (int k = 0; k < NB; k++) begin
                        if (idx == 8'(k)) begin
                           next_regs[k] = (regs[k] & ~WR_MASK[8*k +: 8])
                              | (shift & WR_MASK[8*k +: 8])
                              | (regs[k] & STICKY[8*k +: 8]);
                        end
                     end
                     // Indices past the bank match no register, so surplus is dropped.
                     next_idx = block ? inc_idx(idx) : `SBC_IDX_NONE;
                  end
                  sbc_pkg::DEV_TX: begin
                     next_sda_low = 1'b0;
                  end
                  default: begin
                     next_state = sbc_pkg::DEV_IGN;
                  end
               endcase
            end else if (bit_cnt == `SBC_ACK_SLOT) begin
               next_bit_cnt = `SBC_FIRST_BIT;
               next_sda_low = 1'b0;
               if (state == sbc_pkg::DEV_TX) begin
                  if (tx_first | acked) begin
                     if (tx_first & block) begin
                        tx_byte = 8'(NB);
                     end else begin
                        tx_byte = rd_byte(idx);
                        next_idx = inc_idx(idx);
                     end
                     next_shift = tx_byte;
                     next_sda_low = ~tx_byte[7];
                     next_tx_first = 1'b0;
                  end else begin
                     next_state = sbc_pkg::DEV_IGN;
                  end
               end
            end else begin
               next_bit_cnt = bit_cnt + 4'h1;
               if (state == sbc_pkg::DEV_TX) begin
                  next_sda_low = ~shift[7];
               end
            end
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state <= sbc_pkg::DEV_IDLE;
         bit_cnt <= `SBC_FIRST_BIT;
         shift <= 8'h00;
         idx <= 8'h00;
         sda_low <= 1'b0;
         block <= 1'b0;
         tx_first <= 1'b0;
         acked <= 1'b0;
         latches <= 1'b0;
         for (int k = 0; k < NB; k++) begin
            regs[k] <= DEFAULTS[8*k +: 8];
         end
      end else begin
         state <= next_state;
         bit_cnt <= next_bit_cnt;
         shift <= next_shift;
         idx <= next_idx;
         sda_low <= next_sda_low;
         block <= next_block;
         tx_first <= next_tx_first;
         acked <= next_acked;
         latches <= next_latches;
         regs <= next_regs;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.

   always_comb begin
      for (int k = 0; k < NB; k++) begin
         cfg_o[8*k +: 8] = regs[k];
      end
   end

   assign latches_open_o = latches;
   assign link.dev_sda_o = 1'b0;
   assign link.dev_sda_oe = sda_low;

endmodule

/* File: hdl/sbc_host.sv */
// Purpose: Host end: SMBus master issuing block and single-byte transfers.
// Assumes: The device never stretches the clock, so SCL is free-running per bit.
// Notes: Outside start, repeated start and stop, SDA changes a quarter after SCL falls, keeping clear of false starts.
`timescale 1ns/1ps
`include "sbc_cfg.svh"
module sbc_host #(
   parameter int QUARTER = `SBC_QUARTER_CYCLES,
   parameter logic [6:0] ADDR7 = `SBC_ADDR7
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   // Request
   input wire logic req_i,
   input wire logic read_i,
   input wire logic [7:0] cmd_i,
   input wire logic [7:0] len_i,
   input wire logic [7:0] wdata_i,
   // Serial link
   sbc_if.host link,
   // Answer
   output logic busy_o,
   output logic wdata_take_o,
   output logic [7:0] rdata_o,
   output logic rdata_valid_o,
   output logic done_o,
   output logic nack_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer.

   sbc_pkg::sbc_host_state_type state;
   sbc_pkg::sbc_host_state_type next_state;
   logic [1:0] q;
   logic [1:0] next_q;
   logic [15:0] qcnt;
   logic [15:0] next_qcnt;
   logic [3:0] bitn;
   logic [3:0] next_bitn;
   logic [7:0] shift;
   logic [7:0] next_shift;
   logic [7:0] left;
   logic [7:0] next_left;
   logic [7:0] cmd;
   logic [7:0] next_cmd;
   logic rd;
   logic next_rd;
   logic scl_low;
   logic next_scl_low;
   logic sda_low;
   logic next_sda_low;
   logic [2:0] sda_s;
   logic [2:0] next_sda_s;
   logic sda_f;
   logic next_sda_f;
   logic [7:0] rdata;
   logic [7:0] next_rdata;
   logic rvalid;
   logic next_rvalid;
   logic done;
   logic next_done;
   logic nack;
   logic next_nack;
   logic take;

   always_comb begin
      logic tick;
      logic is_tx;
      logic is_rx;
      logic give_ack;
      tick = (qcnt == 16'(QUARTER - 1));
      is_rx = (state == sbc_pkg::HST_RCOUNT) || (state == sbc_pkg::HST_RDATA);
      is_tx = (state == sbc_pkg::HST_ADDR) || (state == sbc_pkg::HST_CMD)
         || (state == sbc_pkg::HST_WCOUNT) || (state == sbc_pkg::HST_WDATA)
         || (state == sbc_pkg::HST_RADDR);
      give_ack = ((state == sbc_pkg::HST_RCOUNT) && (left != 8'h00))
         || ((state == sbc_pkg::HST_RDATA) && (left > 8'h01));
      next_sda_s = {sda_s[1:0], link.sda};
      next_sda_f = (sda_s[1] == sda_s[2]) ? sda_s[2] : sda_f;
      next_state = state;
      next_q = q;
      next_qcnt = qcnt;
      next_bitn = bitn;
      next_shift = shift;
      next_left = left;
      next_cmd = cmd;
      next_rd = rd;
      next_rdata = rdata;
      next_nack = nack;
      next_rvalid = 1'b0;
      next_done = 1'b0;
      take = 1'b0;
      if (state == sbc_pkg::HST_IDLE) begin
         next_q = 2'h0;
         next_qcnt = 16'h0000;
         if (req_i) begin
            next_state = sbc_pkg::HST_START;
            next_cmd = cmd_i;
            next_rd = read_i;
            next_left = cmd_i[`SBC_CMD_SINGLE_BIT] ? 8'h01 : len_i;
            next_nack = 1'b0;
         end
      end else begin
         next_qcnt = tick ? 16'h0000 : qcnt + 16'h0001;
         if (tick) begin
            next_q = q + 2'h1;
         end
         if (tick && q == `SBC_LAST_QUARTER) begin
            unique case (state)
               sbc_pkg::HST_START: begin
                  next_state = sbc_pkg::HST_ADDR;
                  next_shift = {ADDR7, `SBC_DIR_WRITE};
                  next_bitn = `SBC_FIRST_BIT;
               end
               sbc_pkg::HST_RSTART: begin
                  next_state = sbc_pkg::HST_RADDR;
                  next_shift = {ADDR7, `SBC_DIR_READ};
                  next_bitn = `SBC_FIRST_BIT;
               end
               sbc_pkg::HST_STOP: begin
                  next_state = sbc_pkg::HST_IDLE;
                  next_done = 1'b1;
               end
               default: begin
                  if (bitn != `SBC_ACK_SLOT) begin
                     next_shift = {shift[6:0], sda_f};
                     next_bitn = bitn + 4'h1;
                  end else begin
                     next_bitn = `SBC_FIRST_BIT;
                     if (is_tx && sda_f) begin
                        next_state = sbc_pkg::HST_STOP;
                        next_nack = 1'b1;
                     end else begin
                        unique case (state)
                           sbc_pkg::HST_ADDR: begin
                              next_state = sbc_pkg::HST_CMD;
                              next_shift = cmd;
                           end
                           sbc_pkg::HST_CMD: begin
                              if (rd) begin
                                 next_state = sbc_pkg::HST_RSTART;
                              end else if (cmd == `SBC_CMD_BLOCK) begin
                                 next_state = sbc_pkg::HST_WCOUNT;
                                 next_shift = left;
                              end else begin
                                 next_state = sbc_pkg::HST_WDATA;
                                 next_shift = wdata_i;
                                 take = 1'b1;
                              end
                           end
                           sbc_pkg::HST_WCOUNT: begin
                              next_state = (left != 8'h00) ? sbc_pkg::HST_WDATA
                                 : sbc_pkg::HST_STOP;
                              next_shift = wdata_i;
                              take = (left != 8'h00);
                           end
                           sbc_pkg::HST_WDATA: begin
                              next_left = left - 8'h01;
                              next_state = (left > 8'h01) ? sbc_pkg::HST_WDATA
                                 : sbc_pkg::HST_STOP;
                              next_shift = wdata_i;
                              take = (left > 8'h01);
                           end
                           sbc_pkg::HST_RADDR: begin
                              next_state = (cmd == `SBC_CMD_BLOCK) ? sbc_pkg::HST_RCOUNT
                                 : sbc_pkg::HST_RDATA;
                           end
                           sbc_pkg::HST_RCOUNT: begin
                              next_state = (left != 8'h00) ? sbc_pkg::HST_RDATA
                                 : sbc_pkg::HST_STOP;
                           end
                           sbc_pkg::HST_RDATA: begin
                              next_rdata = shift;
                              next_rvalid = 1'b1;
                              next_left = left - 8'h01;
                              next_state = (left > 8'h01) ? sbc_pkg::HST_RDATA
                                 : sbc_pkg::HST_STOP;
                           end
                           default: begin
                              next_state = sbc_pkg::HST_STOP;
                           end
                        endcase
                     end
                  end
               end
            endcase
         end
      end
      unique case (state)
         sbc_pkg::HST_IDLE: begin
            next_scl_low = 1'b0;
            next_sda_low = 1'b0;
         end
         sbc_pkg::HST_START: begin
            next_scl_low = 1'b0;
            next_sda_low = q[1];
         end
         sbc_pkg::HST_RSTART: begin
            next_scl_low = ~q[1];
            next_sda_low = (q == 2'h0) ? sda_low : (q == `SBC_LAST_QUARTER);
         end
         sbc_pkg::HST_STOP: begin
            next_scl_low = ~q[1];
            next_sda_low = (q == 2'h0) ? sda_low : (q != `SBC_LAST_QUARTER);
         end
         default: begin
            next_scl_low = ~q[1];
            if (q == 2'h0) begin
               next_sda_low = sda_low;
            end else if (bitn == `SBC_ACK_SLOT) begin
               next_sda_low = is_rx & give_ack;
            end else begin
               next_sda_low = is_tx & ~shift[7];
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state <= sbc_pkg::HST_IDLE;
         q <= 2'h0;
         qcnt <= 16'h0000;
         bitn <= `SBC_FIRST_BIT;
         shift <= 8'h00;
         left <= 8'h00;
         cmd <= 8'h00;
         rd <= 1'b0;
         scl_low <= 1'b0;
         sda_low <= 1'b0;
         sda_s <= 3'h7;
         sda_f <= 1'b1;
         rdata <= 8'h00;
         rvalid <= 1'b0;
         done <= 1'b0;
         nack <= 1'b0;
      end else begin
         state <= next_state;
         q <= next_q;
         qcnt <= next_qcnt;
         bitn <= next_bitn;
         shift <= next_shift;
         left <= next_left;
         cmd <= next_cmd;
         rd <= next_rd;
         scl_low <= next_scl_low;
         sda_low <= next_sda_low;
         sda_s <= next_sda_s;
         sda_f <= next_sda_f;
         rdata <= next_rdata;
         rvalid <= next_rvalid;
         done <= next_done;
         nack <= next_nack;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.

   assign busy_o = (state != sbc_pkg::HST_IDLE);
   assign wdata_take_o = take;
   assign rdata_o = rdata;
   assign rdata_valid_o = rvalid;
   assign done_o = done;
   assign nack_o = nack;
   assign link.host_scl_o = 1'b0;
   assign link.host_scl_oe = scl_low;
   assign link.host_sda_o = 1'b0;
   assign link.host_sda_oe = sda_low;

endmodule

/* File: test/sbc_link_checker.sv */
// Purpose: Wire checks between the host and device ends.
// Assumes: Open-drain wires with pull-ups.
// Notes: Device timing is judged against SCL on the wire.
`timescale 1ns/1ps
module sbc_link_checker (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   // Link
   input wire logic host_scl_o,
   input wire logic host_sda_o,
   input wire logic dev_sda_o,
   input wire logic dev_sda_oe,
   input wire logic scl,
   input wire logic sda
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);
   property p_dev_od; dev_sda_o == 1'b0; endproperty
   a_dev_od: assert property (p_dev_od) else $error("device sda high");
   property p_host_od; host_scl_o == 1'b0 && host_sda_o == 1'b0; endproperty
   a_host_od: assert property (p_host_od) else $error("host wire high");
   property p_stop_free; scl && $rose(sda) |-> !dev_sda_oe; endproperty
   a_stop_free: assert property (p_stop_free) else $error("device held stop");
   property p_start_free; scl && $fell(sda) |-> !dev_sda_oe; endproperty
   a_start_free: assert property (p_start_free) else $error("device made start");
   property p_hold_hi; scl && $past(scl) |-> $stable(dev_sda_oe); endproperty
   a_hold_hi: assert property (p_hold_hi) else $error("sda moved, scl high");
   property p_chg_low; $changed(dev_sda_oe) |-> !scl; endproperty
   a_chg_low: assert property (p_chg_low) else $error("sda moved off low");
   property p_lag; $fell(scl) |=> $stable(dev_sda_oe)[*2]; endproperty
   a_lag: assert property (p_lag) else $error("device answered early");
   property p_bound; $rose(dev_sda_oe) |-> ##[1:160] !dev_sda_oe; endproperty
   a_bound: assert property (p_bound) else $error("device held sda");
endmodule

/* File: test/smbus_block_config_slave_tb.sv */
// Purpose: Bench joining host and device ends over the link.
// Assumes: Power-down is only asked while the link is idle.
// Notes: Read bytes are taken from the tail, so a count byte does not matter.
`timescale 1ns/1ps
`include "sbc_cfg.svh"
module smbus_block_config_slave_tb;
   localparam logic [63:0] DEF = `SBC_REG_DEFAULTS;
   localparam logic [63:0] WM = `SBC_WR_MASK;
   localparam logic [63:0] ST = `SBC_STICKY_MASK;
   logic ref_clk_i = 1'b0, rstn_i = 1'b0, pd_n = 1'b1, req_i = 1'b0, read_i = 1'b0;
   logic [7:0] cmd_i = 8'h00, len_i = 8'h00, wdata_i = 8'h00, rdata;
   logic take, rvalid, done, nack, lopen, busy;
   logic [63:0] cfg, model;
   logic [7:0] wq [16];
   logic [7:0] rq [$];
   int widx = 0, failures = 0, num_checks = 0, cyc = 0, seed = 10277;
   sbc_if sbc_if_inst ();
   sbc_host sbc_host_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .req_i(req_i),
      .read_i(read_i), .cmd_i(cmd_i), .len_i(len_i), .wdata_i(wdata_i),
      .link(sbc_if_inst.host), .busy_o(busy), .wdata_take_o(take), .rdata_o(rdata),
      .rdata_valid_o(rvalid), .done_o(done), .nack_o(nack));
   sbc_dev sbc_dev_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
      .powerdown_request_n_i(pd_n), .link(sbc_if_inst.dev), .cfg_o(cfg), .latches_open_o(lopen));
   sbc_link_checker sbc_link_checker_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
      .host_scl_o(sbc_if_inst.host_scl_o), .host_sda_o(sbc_if_inst.host_sda_o),
      .dev_sda_o(sbc_if_inst.dev_sda_o), .dev_sda_oe(sbc_if_inst.dev_sda_oe),
      .scl(sbc_if_inst.scl), .sda(sbc_if_inst.sda));
   initial forever #10 ref_clk_i = ~ref_clk_i;
   always @(negedge ref_clk_i) wdata_i <= wq[widx[3:0]];
   always @(posedge ref_clk_i) begin
      if (take) widx <= widx + 1;
      if (rvalid) rq.push_back(rdata);
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         give_verdict();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////////////////
   function automatic logic [63:0] put(input logic [63:0] m, input int i, input logic [7:0] b);
      logic [63:0] nv;
      nv = m;
      if (i < 8) nv[8*i+:8] = (m[8*i+:8] & ~WM[8*i+:8]) | (b & WM[8*i+:8]) | (m[8*i+:8] & ST[8*i+:8]);
      return nv;
   endfunction
   task chk(input string nm, input logic [63:0] e, input logic [63:0] s);
      num_checks++;
      if (s !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   task xfer(input logic rd, input logic [7:0] c, input logic [7:0] n);
      int t;
      widx = 0;
      rq.delete();
      @(negedge ref_clk_i);
      {read_i, cmd_i, len_i, req_i} = {rd, c, n, 1'b1};
      @(negedge ref_clk_i);
      req_i = 1'b0;
      chk("busy", 64'h1, {63'h0, busy});
      for (t = 0; done !== 1'b1 && t < 5000; t++) @(negedge ref_clk_i);
      if (t == 5000) failures++;
      repeat (4) @(negedge ref_clk_i);
      chk("idle", 64'h0, {63'h0, busy});
   endtask
   // Byte 0 keeps bit 0 set so these writes never arm the power-down clear.
   task wr(input logic [7:0] c, input int n, input int base);
      for (int i = 0; i < n; i++) begin
         wq[i] = $random(seed);
         if (base + i == 0) wq[i][0] = 1'b1;
         model = put(model, base + i, wq[i]);
      end
      xfer(1'b0, c, n[7:0]);
      chk("nack", 64'h0, {63'h0, nack});
      chk("cfg", model, cfg);
   endtask
   task rd(input logic [7:0] c, input int n, input int base);
      xfer(1'b1, c, n[7:0]);
      chk("rlen", 64'h1, {63'h0, rq.size() == n});
      for (int i = 0; i < n; i++) chk("rdata", model[8*(base+i)+:8], rq[rq.size()-n+i]);
   endtask
   task give_verdict();
      if (failures == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(negedge ref_clk_i);
      rstn_i = 1'b1;
      repeat (4) @(negedge ref_clk_i);
      model = DEF;
      chk("reset", DEF, cfg);
      wr(8'h00, 3, 0);
      rd(8'h00, 8, 0);
      wr(8'h00, 10, 0);
      wr(8'h85, 1, 5);
      rd(8'h85, 1, 5);
      pd_n = 1'b0;
      repeat (20) @(negedge ref_clk_i);
      chk("legacy_open", 64'h0, {63'h0, lopen});
      chk("legacy", model, cfg);
      pd_n = 1'b1;
      wq[0] = 8'h00;
      model = put(model, 0, 8'h00);
      xfer(1'b0, 8'h80, 8'h01);
      chk("arm", model, cfg);
      pd_n = 1'b0;
      repeat (10) @(negedge ref_clk_i);
      chk("clear_open", 64'h1, {63'h0, lopen});
      chk("clear", DEF, cfg);
      pd_n = 1'b1;
      repeat (10) @(negedge ref_clk_i);
      chk("reopen", 64'h0, {63'h0, lopen});
      xfer(1'b0, 8'h05, 8'h01);
      chk("refuse", 64'h1, {63'h0, nack});
      chk("refuse_cfg", DEF, cfg);
      give_verdict();
   end
endmodule
